// file: verilog/bcl_pkg.sv
// constants and types for the cache line / latency / header dword
// Function
// - 8-bit read/write cache line size in low byte, counted in dwords.
// - line size sizes read prefetch and feeds the write-and-invalidate line output.
// - non power-of-two line size behaves as sixteen dwords.
// - prefetch honours sizes 16 to 64 dwords; 128 unsupported.
// - computed prefetch count never falls below sixteen dwords.
// - write-and-invalidate supports only sizes 1, 2, 4, 8, 16.
// - latency field counts clocks from own frame assertion to expiry.
// - five upper latency bits writable, eight-clock granularity.
// - three low latency bits read-only zero.
// - zero latency: leave bus after first transfer once grant drops, not MWI.
// - header type byte read-only, returns 0x01.
// - header type selects bridge layout for offsets 0x10 to 0x3F.
// - top byte reserved, reads zero.
// - reset clears line size and latency timer.
package bcl_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] BCL_DWORD_OFFSET  = 8'h0C;
  localparam logic [7:0] BCL_LINE_RESET    = 8'h00;
  localparam logic [4:0] BCL_LAT_RESET     = 5'h00;
  localparam logic [7:0] BCL_HEADER_TYPE   = 8'h01;
  localparam logic [7:0] BCL_RSVD_VALUE    = 8'h00;
  localparam int         BCL_LINE_LSB      = 0;
  localparam int         BCL_LAT_LSB       = 11;
  localparam int         BCL_HTYPE_LSB     = 16;
  localparam int         BCL_RSVD_LSB      = 24;
  // ==========================================================
  // line size and prefetch limits, in dwords
  localparam logic [7:0] BCL_LINE_FALLBACK = 8'h10;
  localparam logic [7:0] BCL_PF_MAX_LINE   = 8'h40;
  localparam logic [7:0] BCL_MWI_MAX_LINE  = 8'h10;
  localparam logic [7:0] BCL_PF_MIN        = 8'h10;
  localparam int         BCL_LAT_SHIFT     = 3;

  typedef struct packed {
    logic       valid;
    logic [7:0] offset;
    logic [3:0] be_n;
    logic       write;
    logic [31:0] wdata;
  } bcl_cfg_req_t;

  typedef enum {BCL_IDLE, BCL_BURST, BCL_LAST} bcl_state_t;
endpackage

// file: verilog/bcl_primary_latency_count.sv
// primary master latency timer counter
`timescale 1ns/100ps
module bcl_primary_latency_count
  import bcl_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_start,
  input  wire logic       i_run,
  input  wire logic [4:0] i_lat,
  output logic            o_expired
);
  logic [7:0] count_r;
  // load lat*8 at own frame assertion, count down each clock while i_run, holding at zero
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
      count_r <= 8'h00;
    else if (i_start)
      count_r <= {i_lat, 3'b000};
    else if (i_run && count_r != 8'h00)
      count_r <= count_r - 8'h01;

  // zero setting expires at once, giving release after first transfer
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
      o_expired <= 1'b0;
    else if (i_start)
      o_expired <= (i_lat == 5'h00);
    else if (i_run)
      o_expired <= (count_r <= 8'h01);
    else
      o_expired <= 1'b0;
endmodule

// file: verilog/bcl_cfg_dword.sv
// cache line size, latency timer and header type dword with master control
`timescale 1ns/100ps
module bcl_cfg_dword
  import bcl_pkg::*;
(
  input  wire logic        I_MCLK,
  input  wire logic        I_RSTN,
  input  wire logic        i_CFG_VALID,
  input  wire logic [7:0]  i_CFG_OFFSET,
  input  wire logic [3:0]  i_CFG_BE_N,
  input  wire logic        i_CFG_WRITE,
  input  wire logic [31:0] i_CFG_WDATA,
  input  wire logic        i_MST_START,
  input  wire logic        i_MST_MWI,
  input  wire logic        i_DATA_XFER,
  input  wire logic        i_GNT_N,
  input  wire logic [7:0]  i_PF_MAX,
  output logic [31:0]      o_CFG_RDATA,
  output logic             o_CFG_HIT,
  output logic [7:0]       o_LINE_SIZE,
  output logic [7:0]       o_PF_COUNT,
  output logic [7:0]       o_MWI_LINE,
  output logic             o_MWI_OK,
  output logic             o_BRIDGE_LAYOUT,
  output logic             o_MST_END
);
  // ==========================================================
  // register storage
  bcl_cfg_req_t req;
  logic [7:0]   line_size_field_r;
  logic [4:0]   primary_latency_count_r;
  logic         hit;
  logic         pow2;
  logic [7:0]   eff_line;
  logic [7:0]   pf_nxt;
  logic [31:0]  rd_nxt;

  logic         expired;

  logic         gnt_s1_r;
  logic         gnt_s2_r;
  logic         gnt_s3_r;
  logic         gnt_n_r;
  bcl_state_t   state_r;

  assign req = '{valid: i_CFG_VALID, offset: i_CFG_OFFSET,
                 be_n: i_CFG_BE_N, write: i_CFG_WRITE,
                 wdata: i_CFG_WDATA};
  assign hit = req.valid && (req.offset == BCL_DWORD_OFFSET);

  // byte lane 0 writes the line size
  always_ff @(posedge I_MCLK or negedge I_RSTN)
    if (!I_RSTN)
      line_size_field_r <= BCL_LINE_RESET;
    else if (hit && req.write && !req.be_n[0])
      line_size_field_r <= req.wdata[BCL_LINE_LSB +: 8];

  // only bits 15:11 take data; lanes 2 and 3 dropped
  always_ff @(posedge I_MCLK or negedge I_RSTN)
    if (!I_RSTN)
      primary_latency_count_r <= BCL_LAT_RESET;
    else if (hit && req.write && !req.be_n[1])
      primary_latency_count_r <= req.wdata[BCL_LAT_LSB +: 5];

  // ==========================================================
  // read path, registered one cycle after the request
  // bits 10:8 never get a source, so they read zero
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    if (hit && !req.write)
    begin
      rd_nxt[BCL_RSVD_LSB +: 8]  = BCL_RSVD_VALUE;
      rd_nxt[BCL_HTYPE_LSB +: 8] = BCL_HEADER_TYPE;
      rd_nxt[BCL_LAT_LSB +: 5]   = primary_latency_count_r;
      rd_nxt[BCL_LINE_LSB +: 8]  = line_size_field_r;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RSTN)
    if (!I_RSTN)
      o_CFG_HIT <= 1'b0;
    else
      o_CFG_HIT <= hit;

  // zero outside read hits, so a stale word never looks valid
  always_ff @(posedge I_MCLK or negedge I_RSTN)
    if (!I_RSTN)
      o_CFG_RDATA <= 32'h0000_0000;
    else
      o_CFG_RDATA <= rd_nxt;

  // ==========================================================
  // line size interpretation
  assign pow2 = (line_size_field_r != 8'h00) &&
                ((line_size_field_r & (line_size_field_r - 8'h01)) == 8'h00);
  // zero treated as non power-of-two too
  assign eff_line = pow2 ? line_size_field_r : BCL_LINE_FALLBACK;

  // prefetch follows line size, raised to i_PF_MAX if larger, capped at 64, floor 16
  always_comb
  begin
    pf_nxt = eff_line;
    if (pf_nxt > BCL_PF_MAX_LINE)
      pf_nxt = BCL_PF_MAX_LINE;
    if (i_PF_MAX > pf_nxt)
      pf_nxt = i_PF_MAX;
    if (pf_nxt > BCL_PF_MAX_LINE)
      pf_nxt = BCL_PF_MAX_LINE;
    if (pf_nxt < BCL_PF_MIN)
      pf_nxt = BCL_PF_MIN;
  end

  // ==========================================================
  // registered views of the line size for the datapath
  always_ff @(posedge I_MCLK or negedge I_RSTN)
    if (!I_RSTN)
      o_LINE_SIZE <= BCL_LINE_FALLBACK;
    else
      o_LINE_SIZE <= eff_line;

  always_ff @(posedge I_MCLK or negedge I_RSTN)
    if (!I_RSTN)
      o_PF_COUNT <= BCL_PF_MIN;
    else
      o_PF_COUNT <= pf_nxt;

  // lines above sixteen are flagged, the burst logic must not use them
  always_ff @(posedge I_MCLK or negedge I_RSTN)
    if (!I_RSTN)
      o_MWI_OK <= 1'b1;
    else
      o_MWI_OK <= (eff_line <= BCL_MWI_MAX_LINE);

  always_ff @(posedge I_MCLK or negedge I_RSTN)
    if (!I_RSTN)
      o_MWI_LINE <= BCL_LINE_FALLBACK;
    else
      o_MWI_LINE <= eff_line;

  always_ff @(posedge I_MCLK or negedge I_RSTN)
    if (!I_RSTN)
      o_BRIDGE_LAYOUT <= 1'b0;
    else
      o_BRIDGE_LAYOUT <= (BCL_HEADER_TYPE[6:0] == 7'h01);

  // ==========================================================
  // grant pin, three-stage sync, change once stages 2 and 3 agree
  // resets to released grant, so a burst can end before the pin is seen
  always_ff @(posedge I_MCLK or negedge I_RSTN)
    if (!I_RSTN)
    begin
      gnt_s1_r <= 1'b1;
      gnt_s2_r <= 1'b1;
      gnt_s3_r <= 1'b1;
    end
    else
    begin
      gnt_s1_r <= i_GNT_N;
      gnt_s2_r <= gnt_s1_r;
      gnt_s3_r <= gnt_s2_r;
    end

  always_ff @(posedge I_MCLK or negedge I_RSTN)
    if (!I_RSTN)
      gnt_n_r <= 1'b1;
    else if (gnt_s2_r == gnt_s3_r)
      gnt_n_r <= gnt_s3_r;


  bcl_primary_latency_count u_timer (
    .i_clk     (I_MCLK),
    .i_rst_n   (I_RSTN),
    .i_start   (i_MST_START),
    .i_run     (state_r == BCL_BURST),
    .i_lat     (primary_latency_count_r),
    .o_expired (expired)
  );

  // ==========================================================
  // master burst control; MWI keeps the bus, an MWI burst never leaves BCL_BURST
  always_ff @(posedge I_MCLK or negedge I_RSTN)
    if (!I_RSTN)
      state_r <= BCL_IDLE;
    else
    begin
      unique case (state_r)
        BCL_IDLE:
          if (i_MST_START)
            state_r <= BCL_BURST;
        BCL_BURST:
          if (expired && gnt_n_r && !i_MST_MWI)
            state_r <= BCL_LAST;
        BCL_LAST:
          if (i_DATA_XFER)
            state_r <= BCL_IDLE;
      endcase
    end

  // end pulse lasts one cycle, the cycle after the data phase that closes the burst
  always_ff @(posedge I_MCLK or negedge I_RSTN)
    if (!I_RSTN)
      o_MST_END <= 1'b0;
    else
      o_MST_END <= (state_r == BCL_LAST) && i_DATA_XFER;

endmodule

// file: tb/bcl_cfg_dword_monitor.sv
// assertion checker for the cache line, latency and header dword
`timescale 1ns/100ps
module bcl_cfg_dword_monitor
  import bcl_pkg::*;
(
  input wire logic        I_MCLK,
  input wire logic        I_RSTN,
  input wire logic        i_CFG_VALID,
  input wire logic [7:0]  i_CFG_OFFSET,
  input wire logic        i_CFG_WRITE,
  input wire logic [31:0] o_CFG_RDATA,
  input wire logic        o_CFG_HIT,
  input wire logic [7:0]  o_LINE_SIZE,
  input wire logic [7:0]  o_PF_COUNT,
  input wire logic [7:0]  o_MWI_LINE,
  input wire logic        o_MWI_OK,
  input wire logic        o_BRIDGE_LAYOUT,
  input wire logic        o_MST_END
);
  // ==========================================================
  // properties
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RSTN);
  a_hit_follows_access: assert property (
    i_CFG_VALID && i_CFG_OFFSET == BCL_DWORD_OFFSET |=> o_CFG_HIT)
    else $error("no hit after access");
  a_header_top_fixed: assert property (
    o_CFG_HIT && !$past(i_CFG_WRITE) |-> o_CFG_RDATA[31:16] == 16'h0001)
    else $error("header or top byte wrong");
  a_lat_low_zero: assert property (
    o_CFG_HIT |-> o_CFG_RDATA[10:8] == 3'h0) else $error("low bits set");
  a_line_pow2: assert property (
    $onehot(o_LINE_SIZE)) else $error("line size not power of two");
  a_pf_in_range: assert property (
    o_PF_COUNT >= 8'h10 && o_PF_COUNT <= 8'h40) else $error("pf range");
  a_mwi_ok_match: assert property (
    o_MWI_OK == (o_MWI_LINE <= 8'h10)) else $error("mwi flag wrong");
  a_layout_after_reset: assert property (
    $past(I_RSTN) |-> o_BRIDGE_LAYOUT) else $error("layout not set");
  a_end_one_cycle: assert property (
    o_MST_END |=> !o_MST_END) else $error("end pulse too long");
endmodule
bind bcl_cfg_dword bcl_cfg_dword_monitor u_mon (.*);

// file: tb/bcl_host_model.sv
// configuration host issuing single-cycle accesses
`timescale 1ns/100ps
module bcl_host_model
  import bcl_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_hit,
  input  wire logic [31:0] i_rdata,
  output bcl_cfg_req_t     o_req
);
  // ==========================================================
  // access: strobe one cycle, answer settles a cycle later
  initial o_req = '0;
  task automatic cfg(input logic w, input logic [7:0] off,
                     input logic [3:0] be_n, input logic [31:0] wd,
                     output logic h, output logic [31:0] rd);
    @(posedge i_clk);
    o_req <= '{1'b1, off, be_n, w, wd};
    @(posedge i_clk);
    // released lines flip so stale values never look valid
    o_req <= '{1'b0, ~off, ~be_n, ~w, ~wd};
    @(negedge i_clk);
    h  = i_hit;
    rd = i_rdata;
  endtask
endmodule

// file: tb/tb.sv
// self-checking bench for the cache line, latency and header dword
`timescale 1ns/100ps
module tb
  import bcl_pkg::*;
;
  logic         mclk = 1'b0, rst_n = 1'b0, gnt_n = 1'b0, h, hit;
  logic         start = 1'b0, mwi = 1'b0, xfer = 1'b0, mok, lay, mend;
  logic [7:0]   pf_max = 8'h08, line, pf, mline;
  logic [31:0]  rdata, r;
  bcl_cfg_req_t req;
  int           num_errors = 0, tests_run = 0, cyc = 0;
  // ==========================================================
  // harness
  always #25 mclk = ~mclk;
  bcl_host_model host (.i_clk(mclk), .i_hit(hit), .i_rdata(rdata),
    .o_req(req));
  bcl_cfg_dword dut (.I_MCLK(mclk), .I_RSTN(rst_n),
    .i_CFG_VALID(req.valid), .i_CFG_OFFSET(req.offset),
    .i_CFG_BE_N(req.be_n), .i_CFG_WRITE(req.write),
    .i_CFG_WDATA(req.wdata), .i_MST_START(start), .i_MST_MWI(mwi),
    .i_DATA_XFER(xfer), .i_GNT_N(gnt_n), .i_PF_MAX(pf_max),
    .o_CFG_RDATA(rdata), .o_CFG_HIT(hit), .o_LINE_SIZE(line),
    .o_PF_COUNT(pf), .o_MWI_LINE(mline), .o_MWI_OK(mok),
    .o_BRIDGE_LAYOUT(lay), .o_MST_END(mend));
  always @(posedge mclk)
    if (++cyc == 5000)
    begin
      num_errors++;
      complete_run();
    end
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] be, input logic [31:0] d);
    host.cfg(w, BCL_DWORD_OFFSET, be, d, h, r);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs;
    acc(1'b0, 4'h0, 32'h0);
    chk("reset dword", 32'h0001_0000, r);
    chk("hit", 1'b1, h);
    chk("reset line", 8'h10, line);
    chk("layout", 1'b1, lay);
    acc(1'b1, 4'h0, 32'hFFFF_FFFF);
    acc(1'b0, 4'h0, 32'h0);
    chk("all ones", 32'h0001_F8FF, r);
    acc(1'b1, 4'hE, 32'h0);
    acc(1'b0, 4'h0, 32'h0);
    chk("lane zero", 32'h0001_F800, r);
    host.cfg(1'b0, 8'h10, 4'h0, 32'h0, h, r);
    chk("miss hit", 1'b0, h);
    chk("miss data", 32'h0, r);
    $display("test registers done");
  endtask
  task automatic t_lines(input logic [7:0] pm);
    logic [7:0] v, e, p;
    logic [7:0] vals [10] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20,
                              8'h40, 8'h80, 8'h03, 8'h00};
    @(posedge mclk);
    pf_max <= pm;
    for (int i = 0; i < 10; i++)
    begin
      v = vals[i];
      e = (v == 8'h00 || (v & (v - 8'h01)) != 8'h00) ? 8'h10 : v;
      p = (e > pm) ? e : pm;
      p = (p < 8'h10) ? 8'h10 : (p > 8'h40) ? 8'h40 : p;
      acc(1'b1, 4'hE, {24'h0, v});
      repeat (4) @(negedge mclk);
      chk("line", e, line);
      chk("mwi ok", e <= 8'h10, mok);
      chk("mwi line", e, mline);
      chk("prefetch", p, pf);
    end
    $display("test lines done");
  endtask
  task automatic t_master(input logic [4:0] lat, input logic m);
    int n = 0;
    acc(1'b1, 4'hD, {16'h0, lat, 11'h0});
    @(posedge mclk);
    {mwi, gnt_n, start} <= {m, 2'b11};
    @(posedge mclk);
    {start, xfer} <= 2'b01;
    while (mend !== 1'b1 && n < 60)
    begin
      @(negedge mclk);
      n++;
    end
    // write-and-invalidate keeps the bus despite lost grant
    if (m)
      chk("mwi end", 60, n);
    else
      chk("end time", 1, n >= lat * 8 && n <= lat * 8 + 10);
    @(posedge mclk);
    {mwi, gnt_n, xfer} <= 3'b000;
    repeat (4) @(posedge mclk);
    $display("test master done");
  endtask
  initial
  begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs();
    t_lines(8'h08);
    t_lines(8'h30);
    t_master(5'h00, 1'b0);
    t_master(5'h01, 1'b0);
    t_master(5'h03, 1'b0);
    t_master(5'h00, 1'b1);
    complete_run();
  end
endmodule
